// ==== tb/lras_host.sv ====
// Host model: strobes, chip select and shared write data
`timescale 1ns/1ns
module lras_host (
  input  wire logic       clk,
  input  wire logic       busy_q,
  output logic            chip_select_n,
  output logic            ctrl_we,
  output logic            x_we,
  output logic            y_we,
  output logic            hz_we,
  output logic            data_wr,
  output logic            data_rd,
  output logic [7:0]      wdata
);
  initial begin
    {data_rd, data_wr, hz_we, y_we, x_we, ctrl_we, chip_select_n} = 7'h00;
    wdata = 8'h00;
  end
  task automatic idle();
    int n = 0;
    while (busy_q !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  // Select moves only when idle
  task automatic sel(input logic v);
    idle();
    chip_select_n = v;
  endtask
  // k: 0 ctrl 1 x 2 y 3 hz 4 write 5 read; loads kept in range
  task automatic pulse(input int k, input logic [7:0] v, input bit w = 1'b1);
    if (w) begin
      idle();
    end
    @(negedge clk);
    wdata = v;
    {data_rd, data_wr, hz_we, y_we, x_we, ctrl_we} = 6'h01 << k;
    @(negedge clk);
    {data_rd, data_wr, hz_we, y_we, x_we, ctrl_we} = 6'h00;
    // Released bus shows the inverse, not a stale copy
    wdata = ~v;
  endtask
endmodule // lras_host

// ==== tb/tb.sv ====
// Self-checking bench for the LCD RAM address sequencer
`timescale 1ns/1ns
module tb;
  localparam int unsigned FS  = 16;
  localparam int unsigned F41 = 18;
  logic        clk, resetn, master_mode_pin, standby_request, v;
  logic        chip_select_n, ctrl_we, x_we, y_we, hz_we, data_wr, data_rd;
  logic [7:0]  wdata, data_rdata_q, ctrl_q;
  logic [6:0]  pix_x;
  logic [5:0]  pix_y, y_q;
  logic [4:0]  x_q;
  logic        busy_q, standby_request_q, serial_out_tristate_q, serial_out_pin_o_q;
  logic        serial_out_pin_oe_n_q, pix_on_q, frame_polarity_out_q;
  logic        frame_start_out_q, shift_clock_out_q, frame_pins_oe_n_q;
  logic        cascade_clock_out_q, osc_pin_two_q, osc_pin_three_q;
  logic [39:0] rows [9];
  int          n_errors, n_compared, cyc, n;
  int          ratio [6] = '{1, 2, 3, 4, 6, 8};

  lras_top #(.FRAME_STD(FS), .FRAME_41(F41)) u_lras_top (
    .clk, .resetn, .master_mode_pin, .chip_select_n, .standby_request,
    .hz_we, .hz_wdata(wdata[0]), .ctrl_we, .ctrl_wdata(wdata), .x_we,
    .x_wdata(wdata[4:0]), .y_we, .y_wdata(wdata[5:0]), .data_wr, .data_rd,
    .data_wdata(wdata), .pix_x, .pix_y, .data_rdata_q, .busy_q, .ctrl_q, .x_q,
    .y_q, .standby_request_q, .serial_out_tristate_q, .serial_out_pin_o_q,
    .serial_out_pin_oe_n_q, .pix_on_q, .frame_polarity_out_q, .frame_start_out_q,
    .shift_clock_out_q, .frame_pins_oe_n_q, .cascade_clock_out_q, .osc_pin_two_q,
    .osc_pin_three_q
  );
  lras_host u_lras_host (
    .clk, .busy_q, .chip_select_n, .ctrl_we, .x_we, .y_we, .hz_we, .data_wr,
    .data_rd, .wdata
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Probe output is registered, so give it two edges
  task automatic pix(input int c, input int r, output logic p);
    @(negedge clk);
    pix_x = 7'(c);
    pix_y = 6'(r);
    repeat (2) @(negedge clk);
    p = pix_on_q;
  endtask
  // Cycles from one frame start to the next, less one
  task automatic gap(output int g);
    g = 0;
    @(negedge clk);
    while (frame_start_out_q !== 1'b1 && g < 400) begin
      @(negedge clk);
      g++;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    master_mode_pin = 1'b1;
    standby_request = 1'b0;
    pix_x = 7'h00;
    pix_y = 6'h00;
    // ctrl, x start, y start, x after, y after
    rows = '{40'h80_0f_03_00_04, 40'hc0_15_2f_00_00, 40'hc0_0f_05_10_05,
             40'h00_03_2f_04_00, 40'h01_03_2b_04_00, 40'h02_0f_28_00_00,
             40'h03_01_20_02_00, 40'h03_01_1f_01_20, 40'h43_15_20_00_00};
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    check(x_q, 8'h00);
    check(serial_out_tristate_q, 8'h01);
    done("reset");
    foreach (rows[i]) begin
      u_lras_host.pulse(0, rows[i][39:32]);
      u_lras_host.pulse(1, rows[i][31:24]);
      u_lras_host.pulse(2, rows[i][23:16]);
      u_lras_host.pulse(4, 8'h00);
      u_lras_host.idle();
      check(x_q, rows[i][15:8]);
      check(y_q, rows[i][7:0]);
    end
    done("counters");
    u_lras_host.pulse(1, 8'h00);
    u_lras_host.pulse(4, 8'h11);
    n = 0;
    while (busy_q === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(8'(n), 8'h08);
    u_lras_host.pulse(4, 8'h22);
    u_lras_host.pulse(4, 8'h33, 1'b0);
    u_lras_host.sel(1'b1);
    u_lras_host.pulse(4, 8'h44);
    u_lras_host.pulse(0, 8'h00);
    u_lras_host.sel(1'b0);
    check(y_q, 8'h02);
    check(ctrl_q, 8'h43);
    done("busy");
    u_lras_host.pulse(0, 8'h80);
    u_lras_host.pulse(1, 8'h02);
    u_lras_host.pulse(2, 8'h04);
    u_lras_host.pulse(4, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      pix(16 + i, 4, v);
      check(8'(v), 8'((8'ha5 >> (7 - i)) & 8'h01));
    end
    u_lras_host.pulse(1, 8'h02);
    u_lras_host.pulse(5, 8'h00);
    u_lras_host.idle();
    check(data_rdata_q, 8'ha5);
    check(serial_out_pin_o_q, 8'h01);
    u_lras_host.pulse(0, 8'hc0);
    u_lras_host.pulse(1, 8'h14);
    u_lras_host.pulse(4, 8'h00);
    u_lras_host.pulse(4, 8'h3f);
    for (int i = 0; i < 4; i++) begin
      pix(124 + i, 4, v);
      check(8'(v), 8'(i > 1));
    end
    check(y_q, 8'h05);
    done("pixels");
    u_lras_host.pulse(3, 8'h00);
    check(serial_out_tristate_q, 8'h00);
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    check({frame_polarity_out_q, frame_start_out_q, shift_clock_out_q,
           frame_pins_oe_n_q}, 8'h08);
    check(serial_out_pin_oe_n_q, 8'h01);
    resetn = 1'b1;
    check(y_q, 8'h00);
    check(serial_out_tristate_q, 8'h01);
    check(ctrl_q, 8'hc0);
    pix(16, 4, v);
    check(8'(v), 8'h01);
    done("mid reset");
    u_lras_host.pulse(3, 8'h00);
    u_lras_host.pulse(0, 8'h83);
    u_lras_host.pulse(2, 8'h05);
    standby_request = 1'b1;
    master_mode_pin = 1'b0;
    u_lras_host.pulse(0, 8'h00);
    repeat (3) @(negedge clk);
    check(standby_request_q, 8'h01);
    check({cascade_clock_out_q, osc_pin_two_q, osc_pin_three_q,
           frame_pins_oe_n_q}, 8'h03);
    master_mode_pin = 1'b1;
    repeat (4) @(negedge clk);
    check({frame_polarity_out_q, frame_start_out_q, shift_clock_out_q,
           frame_pins_oe_n_q, cascade_clock_out_q}, 8'h10);
    standby_request = 1'b0;
    repeat (3) @(negedge clk);
    check({standby_request_q, serial_out_tristate_q, y_q}, 8'h00);
    check(serial_out_pin_oe_n_q, 8'h00);
    check(ctrl_q, 8'h83);
    pix(16, 4, v);
    check(8'(v), 8'h01);
    done("standby");
    // Divider codes 0..5, duties taken in turn
    for (int c = 0; c < 6; c++) begin
      u_lras_host.pulse(0, 8'(c * 4 + c % 4));
      gap(n);
      gap(n);
      check(8'(n + 1), 8'(ratio[c] * (c % 4 == 2 ? F41 : FS)));
    end
    done("frame");
    print_verdict();
  end
endmodule // tb

// ==== verilog/lras_pkg.sv ====
// Constants shared by the LCD RAM address sequencer
package lras_pkg;
  localparam int unsigned RAM_ROWS      = 48;
  localparam int unsigned RAM_COLS      = 128;
  localparam logic [4:0]  X_MAX_W8      = 5'h0f;
  localparam logic [4:0]  X_MAX_W6      = 5'h15;
  localparam logic [5:0]  Y_MAX_D48     = 6'h2f;
  localparam logic [5:0]  Y_MAX_D44     = 6'h2b;
  localparam logic [5:0]  Y_MAX_D41     = 6'h28;
  localparam logic [5:0]  Y_MAX_D33     = 6'h20;
  localparam logic [1:0]  DUTY_48       = 2'h0;
  localparam logic [1:0]  DUTY_44       = 2'h1;
  localparam logic [1:0]  DUTY_41       = 2'h2;
  localparam logic [1:0]  DUTY_33       = 2'h3;
  localparam int unsigned CTL_INC_BIT   = 7;
  localparam int unsigned CTL_WLS_BIT   = 6;
  localparam logic [7:0]  CTL_WR_MASK   = 8'hdf;
  localparam int unsigned FRAME_LEN_STD = 4224;
  localparam int unsigned FRAME_LEN_41  = 4264;
  localparam logic [3:0]  BUSY_CYC      = 4'h8;
  localparam logic [3:0]  DIV_R1        = 4'h1;
  localparam logic [3:0]  DIV_R2        = 4'h2;
  localparam logic [3:0]  DIV_R3        = 4'h3;
  localparam logic [3:0]  DIV_R4        = 4'h4;
  localparam logic [3:0]  DIV_R6        = 4'h6;
  localparam logic [3:0]  DIV_R8        = 4'h8;
  localparam logic        HZ_RESET      = 1'b1;
  localparam logic [4:0]  X_RESET       = 5'h00;
  localparam logic [5:0]  Y_RESET       = 6'h00;
  typedef enum logic {LRAS_RUN, LRAS_STANDBY_REQUEST} lras_state_t;
endpackage

// ==== verilog/lras_top.sv ====
// LCD display RAM, X/Y auto-increment counters, busy timer and frame timing
// Summary of operation
// - Reset sets serial-out tristate bit, clears other address register bits.
// - Reset leaves display RAM contents untouched.
// - Reset keeps control register, clears both address counters.
// - Standby cancel clears standby bit and both counters, keeps other bits.
// - RAM and control register survive standby unchanged.
// - Reset/standby: master drives polarity high, start and shift low; slave floats.
// - Each data read or write steps the counter chosen by direction bit; its wrap also steps the other.
// - X counts 0..15 for 8-bit words, 0..21 for 6-bit words.
// - X-increment mode: X wrap to zero also steps Y.
// - Y counts 0..32, 40, 43 or 47 by duty.
// - Y-increment mode: Y wrap to zero also steps X.
// - Word MSB lands on first column, later bits on following columns.
// - Stored one lights the pixel, zero darkens it.
// - 6-bit words at X 21 store only two upper bits.
// - Frame lasts 4224 divided clocks, or 4264 at duty 1/41.
// - Each RAM access keeps busy at most 8 undivided clocks.
// - Direction bit one selects X increment, zero Y increment.
// - Word length bit one means 6-bit accesses, zero 8-bit.
// - Duty code 0..3 means 1/48, 1/44, 1/41, 1/33.
`timescale 1ns/1ns
module lras_top #(
  parameter int unsigned FRAME_STD = lras_pkg::FRAME_LEN_STD,
  parameter int unsigned FRAME_41  = lras_pkg::FRAME_LEN_41
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       master_mode_pin,
  input  wire logic       chip_select_n,
  input  wire logic       standby_request,
  input  wire logic       hz_we,
  input  wire logic       hz_wdata,
  input  wire logic       ctrl_we,
  input  wire logic [7:0] ctrl_wdata,
  input  wire logic       x_we,
  input  wire logic [4:0] x_wdata,
  input  wire logic       y_we,
  input  wire logic [5:0] y_wdata,
  input  wire logic       data_wr,
  input  wire logic       data_rd,
  input  wire logic [7:0] data_wdata,
  input  wire logic [6:0] pix_x,
  input  wire logic [5:0] pix_y,
  output logic [7:0]      data_rdata_q,
  output logic            busy_q,
  output logic [7:0]      ctrl_q,
  output logic [4:0]      x_q,
  output logic [5:0]      y_q,
  output logic            standby_request_q,
  output logic            serial_out_tristate_q,
  output logic            serial_out_pin_o_q,
  output logic            serial_out_pin_oe_n_q,
  output logic            pix_on_q,
  output logic            frame_polarity_out_q,
  output logic            frame_start_out_q,
  output logic            shift_clock_out_q,
  output logic            frame_pins_oe_n_q,
  output logic            cascade_clock_out_q,
  output logic            osc_pin_two_q,
  output logic            osc_pin_three_q
);
  import lras_pkg::*;

  function automatic logic [4:0] x_max(input logic word_length_select);
    x_max = word_length_select ? X_MAX_W6 : X_MAX_W8;
  endfunction

  function automatic logic [5:0] y_max(input logic [1:0] duty);
    case (duty)
      DUTY_48: y_max = Y_MAX_D48;
      DUTY_44: y_max = Y_MAX_D44;
      DUTY_41: y_max = Y_MAX_D41;
      default: y_max = Y_MAX_D33;
    endcase
  endfunction

  function automatic logic [3:0] div_ratio(input logic [2:0] ffs);
    case (ffs)
      3'h0:    div_ratio = DIV_R1;
      3'h1:    div_ratio = DIV_R2;
      3'h2:    div_ratio = DIV_R3;
      3'h3:    div_ratio = DIV_R4;
      3'h4:    div_ratio = DIV_R6;
      3'h5:    div_ratio = DIV_R8;
      default: div_ratio = DIV_R1; // Test codes: treated as undivided
    endcase
  endfunction

  localparam logic [12:0] FLEN_STD = 13'(FRAME_STD - 1);
  localparam logic [12:0] FLEN_41  = 13'(FRAME_41 - 1);

  logic        ms_meta_q, master_q;
  logic        ctrl_set_q;
  logic [RAM_COLS-1:0] mem_q [RAM_ROWS];
  logic [3:0]  busy_cnt_q;
  logic [3:0]  div_cnt_q;
  logic [12:0] frame_cnt_q;
  lras_state_t state_q;

  logic        inc_x, word_length_select, acc, hold, div_tick, frame_end, standby_request_cancel;
  logic [1:0]  duty;
  logic [4:0]  xm;
  logic [5:0]  ym;
  logic [7:0]  base;
  logic [3:0]  wlen;

  assign inc_x = ctrl_q[CTL_INC_BIT];
  assign word_length_select   = ctrl_q[CTL_WLS_BIT];
  assign duty  = ctrl_q[1:0];
  assign xm    = x_max(word_length_select);
  assign ym    = y_max(duty);
  assign wlen  = word_length_select ? 4'h6 : 4'h8;
  // Column of the word MSB: X times word length
  assign base  = word_length_select ? (8'({x_q, 2'b00}) + 8'({x_q, 1'b0})) : 8'({x_q, 3'b000});
  // Busy accesses are dropped, the host is expected to poll busy first
  assign acc   = resetn && !chip_select_n && !busy_q && !standby_request_q && (data_wr || data_rd);
  assign hold  = !resetn || standby_request_q;
  assign standby_request_cancel = standby_request_q && !standby_request;
  // At or past the end, so a shorter new setting cannot strand a count
  assign div_tick  = !standby_request_q && (div_cnt_q >= div_ratio(ctrl_q[4:2]) - 4'h1);
  assign frame_end = div_tick && (frame_cnt_q >= ((duty == DUTY_41) ? FLEN_41 : FLEN_STD));

  // Master/slave strap is a pin: two stages before use
  always_ff @(posedge clk) begin
    ms_meta_q <= master_mode_pin;
    master_q  <= ms_meta_q;
  end

  // Control register has no reset on purpose: it must survive the reset pin
  always_ff @(posedge clk) begin
    if (resetn && ctrl_we && !standby_request_q && !chip_select_n) begin
      ctrl_q     <= ctrl_wdata & CTL_WR_MASK;
      ctrl_set_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= LRAS_RUN;
      standby_request_q  <= 1'b0;
    end else begin
      case (state_q)
        LRAS_RUN: begin
          if (standby_request && !busy_q) begin
            state_q <= LRAS_STANDBY_REQUEST;
            standby_request_q  <= 1'b1;
          end
        end
        LRAS_STANDBY_REQUEST: begin
          if (!standby_request) begin
            state_q <= LRAS_RUN;
            standby_request_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= LRAS_RUN;
          standby_request_q  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_out_tristate_q <= HZ_RESET;
      serial_out_pin_oe_n_q <= HZ_RESET;
      serial_out_pin_o_q    <= 1'b0;
    end else begin
      if (hz_we && !chip_select_n) begin
        serial_out_tristate_q <= hz_wdata;
      end
      serial_out_pin_oe_n_q <= standby_request_q || serial_out_tristate_q;
      serial_out_pin_o_q    <= data_rdata_q[7];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || standby_request_cancel) begin
      x_q <= X_RESET;
      y_q <= Y_RESET;
    end else if (x_we && !chip_select_n && !busy_q) begin
      x_q <= x_wdata;
    end else if (y_we && !chip_select_n && !busy_q) begin
      y_q <= y_wdata;
    end else if (acc) begin
      if (inc_x) begin
        if (x_q == xm) begin
          x_q <= 5'h00;
          y_q <= (y_q == ym) ? 6'h00 : y_q + 6'h01;
        end else begin
          x_q <= x_q + 5'h01;
        end
      end else begin
        if (y_q == ym) begin
          y_q <= 6'h00;
          x_q <= (x_q == xm) ? 5'h00 : x_q + 5'h01;
        end else begin
          y_q <= y_q + 6'h01;
        end
      end
    end
  end

  // RAM is never reset or cleared by standby
  always_ff @(posedge clk) begin
    if (acc && data_wr) begin
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < wlen && (base + 8'(i)) < 8'(RAM_COLS)) begin
          mem_q[y_q][7'(base + 8'(i))] <= data_wdata[3'(wlen - 4'(i) - 4'h1)];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (acc && data_rd) begin
      // Unused and discarded bits read as zero
      data_rdata_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < wlen && (base + 8'(i)) < 8'(RAM_COLS)) begin
          data_rdata_q[3'(wlen - 4'(i) - 4'h1)] <= mem_q[y_q][7'(base + 8'(i))];
        end
      end
    end else if (!resetn) begin
      data_rdata_q <= 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    pix_on_q <= mem_q[pix_y][pix_x];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= 4'h0;
    end else if (acc) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= BUSY_CYC - 4'h1;
    end else if (busy_q) begin
      if (busy_cnt_q == 4'h0) begin
        busy_q <= 1'b0;
      end else begin
        busy_cnt_q <= busy_cnt_q - 4'h1;
      end
    end
  end

  // Oscillator stand-in: frozen in standby so nothing toggles
  always_ff @(posedge clk) begin
    if (!resetn) begin
      osc_pin_two_q       <= 1'b0;
      osc_pin_three_q     <= 1'b1;
      cascade_clock_out_q <= 1'b0;
    end else if (standby_request_q) begin
      osc_pin_two_q       <= 1'b0;
      osc_pin_three_q     <= 1'b1;
      cascade_clock_out_q <= 1'b0;
    end else begin
      osc_pin_two_q       <= !osc_pin_two_q;
      osc_pin_three_q     <= osc_pin_two_q;
      cascade_clock_out_q <= !osc_pin_two_q;
    end
  end

  always_ff @(posedge clk) begin
    if (hold) begin
      div_cnt_q   <= 4'h0;
      frame_cnt_q <= 13'h0000;
    end else if (div_tick) begin
      div_cnt_q   <= 4'h0;
      frame_cnt_q <= frame_end ? 13'h0000 : frame_cnt_q + 13'h0001;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // Slave floats its frame pins all the time; the master feeds them
  always_ff @(posedge clk) begin
    frame_pins_oe_n_q <= !master_q;
    if (hold) begin
      frame_polarity_out_q <= 1'b1;
      frame_start_out_q    <= 1'b0;
      shift_clock_out_q    <= 1'b0;
    end else begin
      if (frame_end) begin
        frame_polarity_out_q <= !frame_polarity_out_q;
      end
      frame_start_out_q <= div_tick && (frame_cnt_q == 13'h0000);
      if (div_tick) begin
        shift_clock_out_q <= !shift_clock_out_q;
      end
    end
  end

  property p_reset_hz;
    @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> serial_out_tristate_q && !standby_request_q && !busy_q
        && x_q == X_RESET && y_q == Y_RESET;
  endproperty
  a_reset_hz: assert property (p_reset_hz) else $error("tristate bit not set by reset");

  property p_reset_ctrl;
    @(posedge clk) disable iff (!resetn)
      // Control is unknown until first written, so only later resets count
      $rose(resetn) && ctrl_set_q |-> ctrl_q == $past(ctrl_q) && x_q == 5'h00 && y_q == 6'h00;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("reset disturbed control");

  property p_standby_request_cancel;
    @(posedge clk) disable iff (!resetn)
      $fell(standby_request_q) |-> x_q == 5'h00 && y_q == 6'h00
        && serial_out_tristate_q == $past(serial_out_tristate_q);
  endproperty
  a_standby_request_cancel: assert property (p_standby_request_cancel) else $error("standby cancel wrong");

  property p_standby_request_keep;
    @(posedge clk) disable iff (!resetn)
      standby_request_q && $past(standby_request_q) |-> $stable(ctrl_q) && !osc_pin_two_q && !cascade_clock_out_q;
  endproperty
  a_standby_request_keep: assert property (p_standby_request_keep) else $error("state moved in standby");

  property p_master_hold;
    @(posedge clk) disable iff (!resetn)
      standby_request_q ##1 standby_request_q |-> frame_polarity_out_q && !frame_start_out_q && !shift_clock_out_q;
  endproperty
  a_master_hold: assert property (p_master_hold) else $error("frame pins not parked");

  property p_x_step;
    @(posedge clk) disable iff (!resetn)
      acc && inc_x && x_q != xm && !x_we && !y_we
        |=> x_q == $past(x_q) + 5'h01 && $stable(y_q);
  endproperty
  a_x_step: assert property (p_x_step) else $error("X step wrong");

  property p_x_wrap;
    @(posedge clk) disable iff (!resetn)
      acc && inc_x && x_q == xm && y_q != ym && !x_we && !y_we
        |=> x_q == 5'h00 && y_q == $past(y_q) + 6'h01;
  endproperty
  a_x_wrap: assert property (p_x_wrap) else $error("X wrap did not step Y");

  property p_y_wrap;
    @(posedge clk) disable iff (!resetn)
      acc && !inc_x && y_q == ym && !x_we && !y_we |=> y_q == 6'h00 && x_q != $past(x_q);
  endproperty
  a_y_wrap: assert property (p_y_wrap) else $error("Y wrap did not step X");

  property p_busy_len;
    @(posedge clk) disable iff (!resetn)
      acc |=> busy_q [*8] ##1 !busy_q;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  c_x_wrap: cover property (@(posedge clk) disable iff (!resetn) acc && inc_x && x_q == xm);
  c_y_wrap: cover property (@(posedge clk) disable iff (!resetn) acc && !inc_x && y_q == ym);
  c_standby_request:   cover property (@(posedge clk) disable iff (!resetn) $fell(standby_request_q));
  c_frame:  cover property (@(posedge clk) disable iff (!resetn) frame_end);
endmodule // lras_top
